// *** rfs_regs.sv ***
// rfs_regs: APB register bank for the fractional-N RF synthesizer settings
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
module rfs_regs
  import rfs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [RFS_ADDR_W-1:0] paddr,
  input wire logic [RFS_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [RFS_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic kicker_calibrated,
  input wire logic load_defaults_instruction,
  output logic [7:0] integer_divide_value,
  output logic [23:0] fraction_word,
  output logic [15:0] deviation_word,
  output logic [15:0] fsk_detect_deviation,
  output logic [7:0] lower_loop_divide,
  output logic [7:0] upper_loop_divide,
  output logic [7:0] loop_divide,
  output logic temp_curve_type1,
  output logic internal_loop_filter_en,
  output logic charge_pump_50ua,
  output logic vco_bias_high,
  output logic vco_bias_mid,
  output logic vco_bias_low,
  output logic vco_bias_auto,
  output logic channels_ready
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [7:0] int_div;
    logic [7:0] frac_h;
    logic [7:0] frac_m;
    logic [7:0] frac_l;
    logic [7:0] dev_h;
    logic [7:0] dev_l;
    logic [6:0] opt;
    logic kick;
    logic [23:0] frac_word;
    logic [7:0] lower;
    logic [7:0] upper;
    logic [15:0] tx_dev;
    logic [15:0] det_dev;
    logic [3:0] vco;
    logic [2:0] chan_sel;
    logic [RFS_NUM_CH-1:0][31:0] chan;
    logic [2:0] cnt;
    logic chan_ready;
    rfs_state_type state;
    logic [RFS_DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } rfs_regs_state_type;

  rfs_regs_state_type s_r;
  rfs_regs_state_type s_nxt;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [7:0] rfs_step_div(input logic [7:0] v, input logic up);
    logic [8:0] r;
    if (up) begin
      r = {1'b0, v} + 9'h001;
    end else begin
      r = {1'b0, v} - 9'h001;
    end
    return r[7:0];
  endfunction

  // one-hot order: high, mid, low, auto
  function automatic logic [3:0] rfs_vco_dec(input logic [1:0] code);
    logic [3:0] d;
    d = 4'h0;
    unique case (code)
      RFS_VCO_HIGH: d = 4'h8;
      RFS_VCO_MID: d = 4'h4;
      RFS_VCO_LOW: d = 4'h2;
      RFS_VCO_AUTO: d = 4'h1;
    endcase
    return d;
  endfunction

  function automatic logic [7:0] rfs_index(input logic [RFS_ADDR_W-1:0] a);
    return a[9:2];
  endfunction

  function automatic logic rfs_hit(input logic [RFS_ADDR_W-1:0] a);
    logic [7:0] i;
    logic ok;
    i = rfs_index(a);
    ok = (a[1:0] == 2'h0) && (a[RFS_ADDR_W-1:10] == 2'h0);
    case (i)
      RFS_IDX_INT_DIV, RFS_IDX_FRAC_H, RFS_IDX_FRAC_M, RFS_IDX_FRAC_L,
      RFS_IDX_DEV_H, RFS_IDX_DEV_L, RFS_IDX_OPT, RFS_IDX_CHAN_SEL,
      RFS_IDX_CHAN_INT, RFS_IDX_CHAN_FH, RFS_IDX_CHAN_FM, RFS_IDX_CHAN_FL,
      RFS_IDX_CHAN_STAT: begin
        return ok;
      end
      default: begin
        return 1'b0;
      end
    endcase
  endfunction

  // entries 0..3 are -4..-1 steps, 4..7 are +1..+4 steps
  function automatic logic [31:0] rfs_chan(
    input logic [7:0] int_div,
    input logic [23:0] frac,
    input logic [2:0] k
  );
    logic signed [3:0] offs;
    logic signed [24:0] f;
    logic [7:0] i;
    if (k < 3'(RFS_CH_SIDE)) begin
      offs = $signed({1'b0, k}) - 4'sh4;
    end else begin
      offs = $signed({1'b0, k}) - 4'sh3;
    end
    f = $signed({frac[23], frac}) + 25'(offs * RFS_CH_STEP_W);
    i = int_div;
    // carry into the integer keeps the fraction within half an integer step (RFS_HALF_W)
    if (f > RFS_HALF_W) begin
      f = f - RFS_SCALE_W;
      i = rfs_step_div(int_div, 1'b1);
    end else if (f < -RFS_HALF_W) begin
      f = f + RFS_SCALE_W;
      i = rfs_step_div(int_div, 1'b0);
    end
    return {i, f[23:0]};
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [7:0] idx;
    logic [7:0] rd;
    logic [31:0] sel_ch;
    logic wr_go;
    idx = rfs_index(paddr);
    rd = 8'h00;
    sel_ch = s_r.chan[s_r.chan_sel];
    wr_go = psel && penable && s_r.pready && pwrite && pstrb[0] && !s_r.pslverr;
    s_nxt = s_r;

    s_nxt.kick = kicker_calibrated;
    s_nxt.frac_word = {s_r.frac_h, s_r.frac_m, s_r.frac_l};
    s_nxt.lower = rfs_step_div(s_r.int_div, 1'b0);
    s_nxt.upper = rfs_step_div(s_r.int_div, 1'b1);
    s_nxt.tx_dev = {s_r.dev_h, s_r.dev_l};
    s_nxt.det_dev = {s_r.dev_h, s_r.dev_l};
    s_nxt.vco = rfs_vco_dec(s_r.opt[RFS_OPT_VCO_HI:RFS_OPT_VCO_LO]);

    // read data and response are prepared in the setup cycle
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;
    unique case (idx)
      RFS_IDX_INT_DIV: rd = s_r.int_div;
      RFS_IDX_FRAC_H: rd = s_r.frac_h;
      RFS_IDX_FRAC_M: rd = s_r.frac_m;
      RFS_IDX_FRAC_L: rd = s_r.frac_l;
      RFS_IDX_DEV_H: rd = s_r.dev_h;
      RFS_IDX_DEV_L: rd = s_r.dev_l;
      RFS_IDX_OPT: rd = {s_r.kick, s_r.opt};
      RFS_IDX_CHAN_SEL: rd = {5'h00, s_r.chan_sel};
      RFS_IDX_CHAN_INT: rd = sel_ch[31:24];
      RFS_IDX_CHAN_FH: rd = sel_ch[23:16];
      RFS_IDX_CHAN_FM: rd = sel_ch[15:8];
      RFS_IDX_CHAN_FL: rd = sel_ch[7:0];
      RFS_IDX_CHAN_STAT: begin
        rd = 8'h00;
        rd[RFS_STAT_READY] = s_r.chan_ready;
        rd[RFS_STAT_BUSY] = (s_r.state == RFS_ST_CALC);
      end
      default: rd = 8'h00;
    endcase
    if (psel && !penable) begin
      s_nxt.pready = 1'b1;
      s_nxt.pslverr = !rfs_hit(paddr);
      s_nxt.prdata = '0;
      if (!pwrite && rfs_hit(paddr)) begin
        s_nxt.prdata = {24'h000000, rd};
      end
    end

    // writes land on the edge where the access phase completes
    if (wr_go) begin
      unique case (idx)
        RFS_IDX_INT_DIV: s_nxt.int_div = pwdata[7:0];
        RFS_IDX_FRAC_H: s_nxt.frac_h = pwdata[7:0];
        RFS_IDX_FRAC_M: s_nxt.frac_m = pwdata[7:0];
        RFS_IDX_FRAC_L: s_nxt.frac_l = pwdata[7:0];
        RFS_IDX_DEV_H: s_nxt.dev_h = pwdata[7:0];
        RFS_IDX_DEV_L: s_nxt.dev_l = pwdata[7:0];
        RFS_IDX_OPT: s_nxt.opt = pwdata[6:0] & RFS_OPT_WMASK;
        RFS_IDX_CHAN_SEL: s_nxt.chan_sel = pwdata[2:0];
        default: begin
        end
      endcase
    end

    // ****************************************************************
    // channel table sequencer, one entry per cycle
    // ****************************************************************
    unique case (s_r.state)
      RFS_ST_IDLE: begin
        if (load_defaults_instruction) begin
          s_nxt.state = RFS_ST_CALC;
          s_nxt.cnt = 3'h0;
          s_nxt.chan_ready = 1'b0;
        end
      end
      RFS_ST_CALC: begin
        // a repeated instruction while busy is ignored
        s_nxt.chan[s_r.cnt] = rfs_chan(s_r.int_div, s_nxt.frac_word, s_r.cnt);
        s_nxt.cnt = s_r.cnt + 3'h1;
        if (s_r.cnt == RFS_CH_LAST) begin
          s_nxt.state = RFS_ST_IDLE;
          s_nxt.chan_ready = 1'b1;
        end
      end
      default: begin
        s_nxt.state = RFS_ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.int_div <= RFS_RST_BYTE;
      s_r.vco <= 4'h1;
      s_r.state <= RFS_ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // modulator
  // ****************************************************************
  rfs_sd_mod u_sd (
    .pclk(pclk),
    .presetn(presetn),
    .fraction_word(s_r.frac_word),
    .lower_loop_divide(s_r.lower),
    .upper_loop_divide(s_r.upper),
    .loop_divide(loop_divide)
  );

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign integer_divide_value = s_r.int_div;
  assign fraction_word = s_r.frac_word;
  assign deviation_word = s_r.tx_dev;
  assign fsk_detect_deviation = s_r.det_dev;
  assign lower_loop_divide = s_r.lower;
  assign upper_loop_divide = s_r.upper;
  assign temp_curve_type1 = s_r.opt[RFS_OPT_TEMP];
  assign internal_loop_filter_en = s_r.opt[RFS_OPT_LPF];
  assign charge_pump_50ua = s_r.opt[RFS_OPT_CP];
  assign vco_bias_high = s_r.vco[3];
  assign vco_bias_mid = s_r.vco[2];
  assign vco_bias_low = s_r.vco[1];
  assign vco_bias_auto = s_r.vco[0];
  assign channels_ready = s_r.chan_ready;

endmodule

// *** rfs_pkg.sv ***
// rfs_pkg: constants and types for the RF synthesizer frequency register bank
package rfs_pkg;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] RFS_IDX_INT_DIV = 8'h05;
  localparam logic [7:0] RFS_IDX_FRAC_H = 8'h06;
  localparam logic [7:0] RFS_IDX_FRAC_M = 8'h07;
  localparam logic [7:0] RFS_IDX_FRAC_L = 8'h08;
  localparam logic [7:0] RFS_IDX_DEV_H = 8'h09;
  localparam logic [7:0] RFS_IDX_DEV_L = 8'h0a;
  localparam logic [7:0] RFS_IDX_OPT = 8'h28;
  localparam logic [7:0] RFS_IDX_CHAN_SEL = 8'h29;
  localparam logic [7:0] RFS_IDX_CHAN_INT = 8'h2a;
  localparam logic [7:0] RFS_IDX_CHAN_FH = 8'h2b;
  localparam logic [7:0] RFS_IDX_CHAN_FM = 8'h2c;
  localparam logic [7:0] RFS_IDX_CHAN_FL = 8'h2d;
  localparam logic [7:0] RFS_IDX_CHAN_STAT = 8'h2e;

  localparam int RFS_ADDR_W = 12;
  localparam int RFS_DATA_W = 32;
  localparam logic [7:0] RFS_RST_BYTE = 8'h00;

  // ****************************************************************
  // options register fields
  // ****************************************************************
  localparam int RFS_OPT_KICK = 7;
  localparam int RFS_OPT_TEMP = 6;
  localparam int RFS_OPT_LPF = 3;
  localparam int RFS_OPT_CP = 2;
  localparam int RFS_OPT_VCO_HI = 1;
  localparam int RFS_OPT_VCO_LO = 0;
  localparam logic [6:0] RFS_OPT_WMASK = 7'h4f;
  localparam logic [1:0] RFS_VCO_HIGH = 2'h3;
  localparam logic [1:0] RFS_VCO_MID = 2'h1;
  localparam logic [1:0] RFS_VCO_LOW = 2'h2;
  localparam logic [1:0] RFS_VCO_AUTO = 2'h0;

  // channel status fields
  localparam int RFS_STAT_READY = 0;
  localparam int RFS_STAT_BUSY = 1;

  // ****************************************************************
  // channel table arithmetic
  // ****************************************************************
  localparam int RFS_NUM_CH = 8;
  localparam int RFS_CH_SIDE = 4;
  localparam logic [2:0] RFS_CH_LAST = 3'h7;
  localparam longint RFS_CH_STEP_HZ = 64'd300000;
  localparam longint RFS_REF_HZ = 64'd24000000;
  localparam longint RFS_FRAC_SCALE = 64'd262147;
  localparam longint RFS_CH_STEP =
    (RFS_CH_STEP_HZ * RFS_FRAC_SCALE + RFS_REF_HZ / 2) / RFS_REF_HZ;
  localparam logic signed [24:0] RFS_CH_STEP_W = 25'(RFS_CH_STEP);
  localparam logic signed [24:0] RFS_SCALE_W = 25'(RFS_FRAC_SCALE);
  localparam logic signed [24:0] RFS_HALF_W = 25'(RFS_FRAC_SCALE / 2);

  // ****************************************************************
  // sigma-delta modulator
  // ****************************************************************
  localparam logic [19:0] RFS_SD_MOD = 20'h40000;
  localparam logic signed [25:0] RFS_SD_BIAS = 26'h0040000;
  localparam logic signed [25:0] RFS_SD_MAX = 26'h0080000;

  typedef enum logic [1:0] {
    RFS_ST_IDLE = 2'b01,
    RFS_ST_CALC = 2'b10
  } rfs_state_type;

endpackage

// *** rfs_sd_mod.sv ***
// rfs_sd_mod: first-order sigma-delta choice between the two loop divides
`timescale 1ns/1ps
module rfs_sd_mod
  import rfs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [23:0] fraction_word,
  input wire logic [7:0] lower_loop_divide,
  input wire logic [7:0] upper_loop_divide,
  output logic [7:0] loop_divide
);

  typedef struct packed {
    logic [19:0] acc;
    logic [7:0] div;
  } rfs_sd_state_type;

  rfs_sd_state_type s_r;
  rfs_sd_state_type s_nxt;

  // lower and upper sit two apart, so the pulse density is (1+f)/2
  always_comb begin
    logic signed [25:0] t;
    logic [19:0] sum;
    t = $signed({{2{fraction_word[23]}}, fraction_word}) + RFS_SD_BIAS;
    sum = 20'h00000;
    s_nxt = s_r;
    // out-of-range fractions saturate rather than wrap
    if (t < 0) begin
      t = 26'h0000000;
    end
    if (t > RFS_SD_MAX) begin
      t = RFS_SD_MAX;
    end
    sum = s_r.acc + {1'b0, t[19:1]};
    if (sum >= RFS_SD_MOD) begin
      s_nxt.acc = sum - RFS_SD_MOD;
      s_nxt.div = upper_loop_divide;
    end else begin
      s_nxt.acc = sum;
      s_nxt.div = lower_loop_divide;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign loop_divide = s_r.div;

endmodule

// *** rfs_regs_props.sv ***
// rfs_regs_props: concurrent checks on the synthesizer register bank ports
`timescale 1ns/1ps
module rfs_regs_props
  import rfs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [RFS_ADDR_W-1:0] paddr,
  input wire logic [RFS_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic load_defaults_instruction,
  input wire logic [7:0] integer_divide_value,
  input wire logic [23:0] fraction_word,
  input wire logic [15:0] deviation_word,
  input wire logic [15:0] fsk_detect_deviation,
  input wire logic [7:0] lower_loop_divide,
  input wire logic [7:0] upper_loop_divide,
  input wire logic temp_curve_type1,
  input wire logic internal_loop_filter_en,
  input wire logic vco_bias_high,
  input wire logic vco_bias_mid,
  input wire logic vco_bias_low,
  input wire logic vco_bias_auto,
  input wire logic channels_ready
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic wr;
  logic [9:0] widx;
  assign wr = psel & penable & pready & pwrite & pstrb[0];
  assign widx = {paddr[9:2], 2'b00};

  a_int_div_write: assert property (wr && widx == {RFS_IDX_INT_DIV, 2'b00}
    |=> integer_divide_value == $past(pwdata[7:0])) else $error("divide write lost");
  a_frac_high_write: assert property (wr && widx == {RFS_IDX_FRAC_H, 2'b00}
    |-> ##2 fraction_word[23:16] == $past(pwdata[7:0], 2)) else $error("fraction byte");
  a_dev_low_write: assert property (wr && widx == {RFS_IDX_DEV_L, 2'b00}
    |-> ##2 deviation_word[7:0] == $past(pwdata[7:0], 2)) else $error("deviation byte");
  a_fsk_same_word: assert property ($past(presetn) && $stable(deviation_word)
    |-> fsk_detect_deviation == deviation_word) else $error("detector word differs");
  a_lower_divide: assert property ($past(presetn)
    |-> lower_loop_divide == 8'($past(integer_divide_value) - 8'h01)) else $error("lower");
  a_upper_divide: assert property ($past(presetn)
    |-> upper_loop_divide == 8'($past(integer_divide_value) + 8'h01)) else $error("upper");
  a_vco_onehot: assert property ($onehot({vco_bias_high, vco_bias_mid, vco_bias_low,
    vco_bias_auto})) else $error("bias decode not one-hot");
  a_vco_decode: assert property (wr && widx == {RFS_IDX_OPT, 2'b00} |-> ##2
    {vco_bias_high, vco_bias_mid, vco_bias_low, vco_bias_auto} == {$past(pwdata[1:0], 2) == 2'h3,
    $past(pwdata[1:0], 2) == 2'h1, $past(pwdata[1:0], 2) == 2'h2,
    $past(pwdata[1:0], 2) == 2'h0}) else $error("bias decode");
  a_opt_bits: assert property (wr && widx == {RFS_IDX_OPT, 2'b00} |=>
    temp_curve_type1 == $past(pwdata[6]) && internal_loop_filter_en == $past(pwdata[3]))
    else $error("options bits");
  a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("access answer timing");
  a_chan_restart: assert property (load_defaults_instruction && channels_ready
    |=> !channels_ready ##8 channels_ready) else $error("channel table timing");
endmodule

bind rfs_regs rfs_regs_props u_props (.*);

// *** tb_top.sv ***
// tb_top: directed bench for the synthesizer register bank
`timescale 1ns/1ps
module tb_top
  import rfs_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pslverr, pready, kicker_calibrated, load;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [7:0] ival, lower, upper, loop_div;
  logic [23:0] frac;
  logic [15:0] dev, fdev;
  logic temp, lpf, cp, vh, vm, vl, va, ready;
  int n_mismatch = 0;
  int comparisons = 0;

  rfs_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .kicker_calibrated(kicker_calibrated),
    .load_defaults_instruction(load), .integer_divide_value(ival), .fraction_word(frac),
    .deviation_word(dev), .fsk_detect_deviation(fdev), .lower_loop_divide(lower),
    .upper_loop_divide(upper), .loop_divide(loop_div), .temp_curve_type1(temp),
    .internal_loop_filter_en(lpf), .charge_pump_50ua(cp), .vco_bias_high(vh),
    .vco_bias_mid(vm), .vco_bias_low(vl), .vco_bias_auto(va), .channels_ready(ready));

  always #10 pclk = ~pclk;

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask

  // ****************************************************************
  // bus cycles
  // ****************************************************************
  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d,
      input logic [3:0] s, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // request stands until ready is seen at a rising edge; the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wrt(input logic [7:0] i, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, i, d, 4'hf, r, e);
  endtask

  task automatic rdc(input logic [7:0] i, input logic [7:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, i, 8'h00, 4'hf, r, e);
    chk("prdata", {24'h0, x}, r);
    chk("pslverr", 32'h0, {31'h0, e});
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    for (int i = 5; i <= 10; i++) rdc(8'(i), 8'h00);
    chk("bias_auto", 32'h1, {31'h0, va});
    chk("lower", 32'hff, {24'h0, lower});
    chk("upper", 32'h01, {24'h0, upper});
  endtask

  task automatic t_freq;
    int hi;
    hi = 0;
    wrt(RFS_IDX_INT_DIV, 8'h26);
    wrt(RFS_IDX_FRAC_H, 8'hfe);
    wrt(RFS_IDX_FRAC_M, 8'h95);
    wrt(RFS_IDX_FRAC_L, 8'h54);
    // the assembled word follows the byte registers one edge later
    repeat (2) @(negedge pclk);
    chk("int", 32'h26, {24'h0, ival});
    chk("frac", 32'hfe9554, {8'h0, frac});
    chk("lower", 32'h25, {24'h0, lower});
    chk("upper", 32'h27, {24'h0, upper});
    rdc(RFS_IDX_FRAC_H, 8'hfe);
    rdc(RFS_IDX_FRAC_L, 8'h54);
    repeat (64) begin
      @(negedge pclk);
      if (loop_div === 8'h27) hi++;
    end
    chk("both_divides", 32'h1, {31'h0, hi > 0 && hi < 64});
  endtask

  task automatic t_dev;
    wrt(RFS_IDX_DEV_H, 8'h08);
    wrt(RFS_IDX_DEV_L, 8'h88);
    repeat (2) @(negedge pclk);
    chk("deviation", 32'h0888, {16'h0, dev});
    chk("detector", 32'h0888, {16'h0, fdev});
    rdc(RFS_IDX_DEV_H, 8'h08);
  endtask

  task automatic t_opts;
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      kicker_calibrated <= c[1];
      // reserved bits written high must read back low
      wrt(RFS_IDX_OPT, {1'b1, c[0], 2'b11, c[0], ~c[0], c});
      rdc(RFS_IDX_OPT, {c[1], c[0], 2'b00, c[0], ~c[0], c});
      chk("bias", {28'h0, c == 2'h3, c == 2'h1, c == 2'h2, c == 2'h0},
        {28'h0, vh, vm, vl, va});
      chk("flags", {29'h0, c[0], c[0], ~c[0]}, {29'h0, temp, lpf, cp});
    end
  endtask

  task automatic t_refuse;
    logic [31:0] r;
    logic e;
    apb(1'b0, 8'h40, 8'h00, 4'hf, r, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, r);
    apb(1'b1, RFS_IDX_INT_DIV, 8'h11, 4'h0, r, e);
    chk("strobe_err", 32'h0, {31'h0, e});
    rdc(RFS_IDX_INT_DIV, 8'h26);
  endtask

  task automatic t_chan;
    int f;
    int n;
    logic [31:0] x;
    for (int p = 0; p < 2; p++) begin
      @(posedge pclk);
      load <= 1'b1;
      @(posedge pclk);
      load <= 1'b0;
      n = 0;
      @(negedge pclk);
      chk("ready_clear", 32'h0, {31'h0, ready});
      while (ready !== 1'b1) begin
        @(negedge pclk);
        n++;
      end
      // one table entry per cycle after the instruction is taken
      chk("ready_delay", 32'(RFS_NUM_CH), 32'(n));
      chk("ready", 32'h1, {31'h0, ready});
    end
    rdc(RFS_IDX_CHAN_STAT, 8'h01);
    for (int k = 0; k < 8; k += 7) begin
      f = -92844 + ((k < 4) ? k - 4 : k - 3) * 3277;
      x = {8'h26, 24'(f)};
      wrt(RFS_IDX_CHAN_SEL, 8'(k));
      rdc(RFS_IDX_CHAN_INT, x[31:24]);
      rdc(RFS_IDX_CHAN_FH, x[23:16]);
      rdc(RFS_IDX_CHAN_FM, x[15:8]);
      rdc(RFS_IDX_CHAN_FL, x[7:0]);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, kicker_calibrated, load} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_freq;
    t_dev;
    t_opts;
    t_refuse;
    t_chan;
    end_of_test;
  end

  initial begin
    #1000000;
    n_mismatch++;
    end_of_test;
  end
endmodule
